// >>> include/flash_guard_consts.vh
`ifndef FLASH_GUARD_CONSTS_VH
`define FLASH_GUARD_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the APB bus
`define OFS_FLASH_KEY      8'h00
`define OFS_STORE_CTL      8'h04
`define OFS_PREFETCH_CTL   8'h08
`define OFS_MOVE_ADDR      8'h0c
`define OFS_MOVE_DATA      8'h10
`define OFS_CODE_READ      8'h14
`define OFS_STATUS         8'h18

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define BIT_STORE_WRITE    0
`define BIT_STORE_ERASE    1
`define BIT_BLOCK_SELECT   0
`define STAT_KEY_LSB       0
`define STAT_HOLD          2
`define STAT_VDD_OK        3
`define STAT_DISABLED      4
`define STAT_LOCK_LSB      8

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_STORE_CTL      2'h0
`define RST_BLOCK_SELECT   1'h0
`define RST_MOVE_ADDR      16'h0000
`define RST_BYTE           8'h00

////////////////////////////////////////////////////////////////////////////////
// Key codes and flash map
`define KEY_FIRST          8'ha5
`define KEY_SECOND         8'hf1
`define ERASED_BYTE        8'hff
`define PAGE_BYTES         10'h200
`define RESERVED_BASE      16'hfc00
`define LOCK_BYTE_ADDR     16'hfbff

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS      20
`define WRITE_TIME_NS      55000
`define WRITE_CYCLES       ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_TIME_NS      15000000
`define ERASE_CYCLES       ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> core/flash_program_erase_guard.v
`include "flash_guard_consts.vh"
`default_nettype none

module flash_program_erase_guard #(
  parameter [23:0] ERASE_CYC = `ERASE_CYCLES,
  parameter [23:0] WRITE_CYC = `WRITE_CYCLES
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Supply monitor enable pin, asynchronous
  input  wire        vdd_monitor_en,
  // Device reset request and activity
  output reg         flash_error_reset,
  output reg         op_busy
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [1:0] KEY_IDLE     = 2'h0;
  localparam [1:0] KEY_FIRST    = 2'h1;
  localparam [1:0] KEY_ARMED    = 2'h2;
  localparam [1:0] KEY_DISABLED = 2'h3;

  localparam [1:0] OP_IDLE  = 2'h0;
  localparam [1:0] OP_PROG  = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;

  localparam [15:0] LOCK_ADDR = `LOCK_BYTE_ADDR;
  localparam [6:0]  LOCK_PAGE = LOCK_ADDR[15:9];

  ////////////////////////////////////////////////////////////////////////////
  // Page lock check from the lock byte; any lock also covers its own page
  function page_locked;
    input [15:0] a;
    input [7:0]  lock_byte;
    reg   [7:0]  n;
    begin
      n = ~lock_byte;
      page_locked = ({1'b0, a[15:9]} < n) ||
                    ((n != 8'h00) && (a[15:9] == LOCK_PAGE));
    end
  endfunction

  function reserved_addr;
    input [15:0] a;
    begin
      reserved_addr = (a >= `RESERVED_BASE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Flash array, erased when the part is fresh
  reg  [7:0]  mem [0:65535];
  integer     i;

  initial begin
    for (i = 0; i < 65536; i = i + 1) begin
      mem[i] = `ERASED_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  reg         vdd_meta_q;
  reg         vdd_ok_q;
  reg  [1:0]  key_q;
  reg  [1:0]  op_q;
  reg  [1:0]  store_ctl_q;
  reg         block_sel_q;
  reg  [15:0] move_addr_q;
  reg  [7:0]  external_data_ram_q;
  reg  [7:0]  hold_data_q;
  reg  [14:0] hold_blk_q;
  reg         hold_valid_q;
  reg  [15:0] prog_addr_q;
  reg  [15:0] prog_data_q;
  reg         prog_two_q;
  reg  [6:0]  erase_page_q;
  reg  [9:0]  erase_idx_q;
  reg  [23:0] timer_q;
  reg         stall_q;

  wire [7:0]  lock_byte = mem[`LOCK_BYTE_ADDR];
  wire [7:0]  wbyte     = pwdata[7:0];
  wire [15:0] maddr     = move_addr_q;
  wire        store_we  = store_ctl_q[`BIT_STORE_WRITE];
  wire        store_ee  = store_ctl_q[`BIT_STORE_ERASE];
  wire        acc       = psel & penable & ~pready & ~stall_q & (op_q == OP_IDLE);
  wire        op_end    = (op_q != OP_IDLE) && (timer_q == 24'h000001);

  wire        hit_key   = (paddr == `OFS_FLASH_KEY);
  wire        hit_ctl   = (paddr == `OFS_STORE_CTL);
  wire        hit_pfe   = (paddr == `OFS_PREFETCH_CTL);
  wire        hit_addr  = (paddr == `OFS_MOVE_ADDR);
  wire        hit_data  = (paddr == `OFS_MOVE_DATA);
  wire        hit_code  = (paddr == `OFS_CODE_READ);
  wire        hit_stat  = (paddr == `OFS_STATUS);
  wire        mapped    = hit_key | hit_ctl | hit_pfe | hit_addr |
                          hit_data | hit_code | hit_stat;

  // Error cases seen by a flash-bound data-move write
  wire        bad_addr  = reserved_addr(maddr) ||
                          page_locked(maddr, lock_byte) ||
                          (store_ee && (maddr[15:9] == LOCK_PAGE));

  ////////////////////////////////////////////////////////////////////////////
  // Array updates; programming ANDs so only a page erase returns a cleared bit to one
  always @(posedge pclk) begin
    if (op_end && (op_q == OP_PROG)) begin
      if (prog_two_q) begin
        mem[{prog_addr_q[15:1], 1'b0}] <=
          mem[{prog_addr_q[15:1], 1'b0}] & prog_data_q[7:0];
        mem[{prog_addr_q[15:1], 1'b1}] <=
          mem[{prog_addr_q[15:1], 1'b1}] & prog_data_q[15:8];
      end else begin
        mem[prog_addr_q] <= mem[prog_addr_q] & prog_data_q[7:0];
      end
    end
    if ((op_q == OP_ERASE) && (erase_idx_q < `PAGE_BYTES)) begin
      mem[{erase_page_q, erase_idx_q[8:0]}] <= `ERASED_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  function [31:0] read_word;
    input [7:0] a;
    begin
      read_word = 32'h00000000;
      if (a == `OFS_STORE_CTL) begin
        read_word[1:0] = store_ctl_q;
      end else if (a == `OFS_PREFETCH_CTL) begin
        read_word[`BIT_BLOCK_SELECT] = block_sel_q;
      end else if (a == `OFS_MOVE_ADDR) begin
        read_word[15:0] = move_addr_q;
      end else if (a == `OFS_MOVE_DATA) begin
        read_word[7:0] = external_data_ram_q;
      end else if (a == `OFS_CODE_READ) begin
        read_word[7:0] = mem[move_addr_q];
      end else if (a == `OFS_STATUS) begin
        read_word[`STAT_KEY_LSB +: 2]  = key_q;
        read_word[`STAT_HOLD]          = hold_valid_q;
        read_word[`STAT_VDD_OK]        = vdd_ok_q;
        read_word[`STAT_DISABLED]      = (key_q == KEY_DISABLED);
        read_word[`STAT_LOCK_LSB +: 8] = lock_byte;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vdd_meta_q        <= 1'b0;
      vdd_ok_q          <= 1'b0;
      key_q             <= KEY_IDLE;
      op_q              <= OP_IDLE;
      store_ctl_q       <= `RST_STORE_CTL;
      block_sel_q       <= `RST_BLOCK_SELECT;
      move_addr_q       <= `RST_MOVE_ADDR;
      external_data_ram_q            <= `RST_BYTE;
      hold_data_q       <= `RST_BYTE;
      hold_blk_q        <= 15'h0000;
      hold_valid_q      <= 1'b0;
      prog_addr_q       <= 16'h0000;
      prog_data_q       <= 16'h0000;
      prog_two_q        <= 1'b0;
      erase_page_q      <= 7'h00;
      erase_idx_q       <= 10'h000;
      timer_q           <= 24'h000000;
      stall_q           <= 1'b0;
      prdata            <= 32'h00000000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      flash_error_reset <= 1'b0;
      op_busy           <= 1'b0;
    end else begin
      vdd_meta_q        <= vdd_monitor_en;
      vdd_ok_q          <= vdd_meta_q;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      flash_error_reset <= 1'b0;

      // Timed operation; the bus stays stalled meanwhile
      if (op_q != OP_IDLE) begin
        timer_q <= timer_q - 24'h000001;
        if ((op_q == OP_ERASE) && (erase_idx_q < `PAGE_BYTES)) begin
          erase_idx_q <= erase_idx_q + 10'h001;
        end
        if (op_end) begin
          op_q    <= OP_IDLE;
          op_busy <= 1'b0;
          stall_q <= 1'b0;
          pready  <= 1'b1;
          if (key_q != KEY_DISABLED) begin
            key_q <= KEY_IDLE;
          end
        end
      end

      if (acc) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h00000000 : read_word(paddr);
        if (pwrite) begin
          if (hit_key) begin
            // Any key write out of place locks out until reset
            case (key_q)
              KEY_IDLE: begin
                key_q <= (wbyte == `KEY_FIRST) ? KEY_FIRST : KEY_DISABLED;
              end
              KEY_FIRST: begin
                key_q <= (wbyte == `KEY_SECOND) ? KEY_ARMED : KEY_DISABLED;
              end
              KEY_ARMED: begin
                key_q <= KEY_DISABLED;
              end
              default: begin
                key_q <= KEY_DISABLED;
              end
            endcase
          end else if (hit_ctl) begin
            store_ctl_q <= pwdata[1:0];
          end else if (hit_pfe) begin
            block_sel_q <= pwdata[`BIT_BLOCK_SELECT];
          end else if (hit_addr) begin
            move_addr_q <= pwdata[15:0];
          end else if (hit_data) begin
            if (!store_we) begin
              external_data_ram_q <= wbyte;
            end else if (!vdd_ok_q) begin
              // The device resets, so the key must not stay armed
              flash_error_reset <= 1'b1;
              if (key_q != KEY_DISABLED) begin
                key_q <= KEY_IDLE;
              end
            end else if (key_q != KEY_ARMED) begin
              key_q <= KEY_DISABLED;
            end else if (bad_addr) begin
              flash_error_reset <= 1'b1;
              key_q             <= KEY_IDLE;
            end else if (store_ee) begin
              // Data byte is ignored; the page is the target
              op_q         <= OP_ERASE;
              op_busy      <= 1'b1;
              erase_page_q <= maddr[15:9];
              erase_idx_q  <= 10'h000;
              timer_q      <= ERASE_CYC;
              stall_q      <= 1'b1;
              pready       <= 1'b0;
            end else if (block_sel_q && !maddr[0]) begin
              // Even byte is only held; no timed step, key consumed
              hold_data_q  <= wbyte;
              hold_blk_q   <= maddr[15:1];
              hold_valid_q <= 1'b1;
              key_q        <= KEY_IDLE;
            end else begin
              op_q        <= OP_PROG;
              op_busy     <= 1'b1;
              prog_addr_q <= maddr;
              timer_q     <= WRITE_CYC;
              stall_q     <= 1'b1;
              pready      <= 1'b0;
              if (block_sel_q) begin
                // Unpaired odd byte leaves the even byte untouched
                prog_two_q   <= 1'b1;
                hold_valid_q <= 1'b0;
                prog_data_q  <= {wbyte,
                  (hold_valid_q && (hold_blk_q == maddr[15:1])) ?
                  hold_data_q : `ERASED_BYTE};
              end else begin
                prog_two_q  <= 1'b0;
                prog_data_q <= {8'h00, wbyte};
              end
            end
          end
        end else if (hit_code) begin
          if (reserved_addr(maddr) || page_locked(maddr, lock_byte)) begin
            flash_error_reset <= 1'b1;
          end
        end
      end
    end
  end

endmodule // flash_program_erase_guard

`default_nettype wire

// >>> sim/core_model.sv
`default_nettype none
module core_model (
  // Clock
  input  wire logic        pclk,
  // APB request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  // APB answer
  input  wire logic        pready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Waits for pready however long a stalled flash operation takes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic keys();
    xfer(1'b1, 8'h00, 32'ha5);
    xfer(1'b1, 8'h00, 32'hf1);
  endtask
endmodule  // core_model
`default_nettype wire

// >>> sim/guard_checker_sva.sv
`default_nettype none
module guard_checker #(
  parameter [23:0] ERASE_CYC = 24'd600,
  parameter [23:0] WRITE_CYC = 24'd4
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  // Flash side
  input wire logic       vdd_monitor_en,
  input wire logic       flash_error_reset,
  input wire logic       op_busy
);
  logic [23:0] busy_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_q <= 24'h0;
    else if (op_busy) busy_cnt_q <= busy_cnt_q + 24'h1;
    else busy_cnt_q <= 24'h0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_move_write;
    s_access ##0 (pwrite && paddr == 8'h10);
  endsequence
  a_plain_answer: assert property (
    s_access ##0 !(pwrite && paddr == 8'h10) |=> pready) else $error("late answer");
  a_move_answer: assert property (
    s_move_write |=> (pready ^ op_busy)) else $error("move write not answered");
  a_stall_ready: assert property (op_busy |-> !pready)
    else $error("ready during operation");
  a_op_ends_ready: assert property ($fell(op_busy) |-> pready)
    else $error("operation end without ready");
  a_op_length: assert property ($fell(op_busy) |->
    (busy_cnt_q + 24'h1 >= WRITE_CYC && busy_cnt_q <= WRITE_CYC + 24'h1) ||
    (busy_cnt_q + 24'h1 >= ERASE_CYC && busy_cnt_q <= ERASE_CYC + 24'h1))
    else $error("operation length wrong");
  a_error_pulse: assert property (flash_error_reset |=> !flash_error_reset)
    else $error("error reset not one cycle");
  a_error_cause: assert property (flash_error_reset |-> $past(psel))
    else $error("error reset without access");
  a_vdd_off_noop: assert property (!vdd_monitor_en [*5] |=> !$rose(op_busy))
    else $error("operation with supply monitor off");
  a_unmapped_err: assert property (pready |->
    pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0)) else $error("slave error wrong");
endmodule  // guard_checker
bind flash_program_erase_guard guard_checker #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC))
  u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .vdd_monitor_en(vdd_monitor_en),
  .flash_error_reset(flash_error_reset), .op_busy(op_busy));
`default_nettype wire

// >>> sim/tb_top.sv
`include "flash_guard_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, vdd_monitor_en, psel, penable, pwrite;
  logic        pready, pslverr, flash_error_reset, op_busy;
  logic [7:0]  paddr, d, x, y;
  logic [31:0] pwdata, prdata;
  logic [15:0] a, e;
  logic [63:0] notes[$];
  logic [63:0] nt;
  int          num_errors, n_compared, errs;
  flash_program_erase_guard #(.ERASE_CYC(24'd600), .WRITE_CYC(24'd4)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vdd_monitor_en(vdd_monitor_en), .flash_error_reset(flash_error_reset), .op_busy(op_busy));
  core_model u_core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge pclk) begin
    if (flash_error_reset === 1'b1) errs++;
    if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      check("prdata", prdata & nt[63:32], nt[31:0]);
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] ex);
    notes.push_back({m, ex & m});
    u_core.xfer(1'b0, ad, 32'h0);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    u_core.xfer(1'b1, ad, v);
  endtask
  task automatic fwr(input logic [15:0] fa, input logic [7:0] v);
    u_core.keys();
    wr(`OFS_MOVE_ADDR, {16'h0, fa});
    wr(`OFS_MOVE_DATA, {24'h0, v});
  endtask
  task automatic frd(input logic [15:0] fa, input logic [7:0] ex);
    wr(`OFS_MOVE_ADDR, {16'h0, fa});
    rd(`OFS_CODE_READ, 32'hff, {24'h0, ex});
  endtask
  task automatic err_is(input int n);
    repeat (2) @(posedge pclk);
    check("error_resets", errs, n);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial begin
    #(40000 * 20);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    vdd_monitor_en = 1'b1;
    d = 8'($urandom(32'h906f));
    do_reset();
    rd(`OFS_STORE_CTL, 32'h3, 32'h0);
    rd(`OFS_PREFETCH_CTL, 32'h1, 32'h0);
    rd(`OFS_MOVE_ADDR, 32'hffff, 32'h0);
    rd(`OFS_STATUS, 32'h1f, 32'h08);
    rd(8'h1c, 32'hffffffff, 32'h0);
    $display("test reset_values done");
    wr(`OFS_STORE_CTL, 32'h1);
    a = {7'd3, 9'($urandom)};
    d = 8'($urandom);
    x = 8'($urandom);
    y = 8'($urandom);
    fwr(a, d);
    frd(a, d);
    rd(`OFS_STATUS, 32'h3, 32'h0);
    fwr(a, x);
    frd(a, d & x);
    $display("test single_byte done");
    wr(`OFS_PREFETCH_CTL, 32'h1);
    e = {7'd4, 8'($urandom), 1'b0};
    fwr(e, x);
    rd(`OFS_STATUS, 32'h4, 32'h4);
    fwr(e + 16'h1, y);
    frd(e, x);
    frd(e + 16'h1, y);
    fwr(e, 8'hff);
    fwr(e + 16'h1, d);
    frd(e, x);
    frd(e + 16'h1, y & d);
    wr(`OFS_PREFETCH_CTL, 32'h0);
    $display("test block_write done");
    wr(`OFS_STORE_CTL, 32'h3);
    fwr({7'd3, 9'h1ff}, d);
    wr(`OFS_STORE_CTL, 32'h0);
    frd(a, 8'hff);
    frd(16'h0600, 8'hff);
    wr(`OFS_MOVE_DATA, 32'h3c);
    rd(`OFS_MOVE_DATA, 32'hff, 32'h3c);
    frd(e, x);
    $display("test erase done");
    vdd_monitor_en <= 1'b0;
    wr(`OFS_STORE_CTL, 32'h1);
    fwr(16'h0a00, 8'h00);
    err_is(1);
    frd(16'h0a00, 8'hff);
    vdd_monitor_en <= 1'b1;
    repeat (3) @(posedge pclk);
    fwr(16'hfc00, 8'h00);
    err_is(2);
    fwr(16'hfbff, 8'hfe);
    rd(`OFS_STATUS, 32'hff00, 32'hfe00);
    fwr(16'h0010, 8'h00);
    err_is(3);
    fwr(16'hfa00, 8'h00);
    err_is(4);
    fwr(16'hfbff, 8'hff);
    err_is(5);
    rd(`OFS_STATUS, 32'hff00, 32'hfe00);
    fwr(16'h0200, 8'h5a);
    frd(16'h0200, 8'h5a);
    $display("test protection done");
    wr(`OFS_FLASH_KEY, 32'ha5);
    wr(`OFS_FLASH_KEY, 32'h00);
    rd(`OFS_STATUS, 32'h13, 32'h13);
    fwr(16'h0c00, 8'h00);
    frd(16'h0c00, 8'hff);
    do_reset();
    rd(`OFS_STATUS, 32'h13, 32'h0);
    wr(`OFS_STORE_CTL, 32'h1);
    wr(`OFS_MOVE_ADDR, 32'h0c00);
    wr(`OFS_MOVE_DATA, 32'h00);
    rd(`OFS_STATUS, 32'h13, 32'h13);
    fwr(16'h0c00, 8'h00);
    frd(16'h0c00, 8'hff);
    err_is(5);
    $display("test key_misuse done");
    tally_and_finish();
  end
endmodule  // tb_top
`default_nettype wire
